// ===== core/trc_ctrl.sv
// control and status logic of a three-data plus one-clock channel retimer
// assumes strap pins and analog status come from outside and are synchronised here
module trc_ctrl
	import trc_pkg::*;
#(
	parameter int NCH = 3
)(
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	// strap pins
	input wire logic [2:0] boost_select_i,
	input wire logic [1:0] deemph_select_i,
	input wire logic bypass_i,
	input wire logic mode_i,
	input wire logic enable_i,
	// analog status
	input wire logic pll_locked_i,
	input wire logic [NCH-1:0] cdr_interp_ok_i,
	input wire logic [NCH:0] above_on_i,
	input wire logic [NCH:0] below_off_i,
	input wire logic link_clk_i,
	// decoded controls
	output trc_path_t path_o,
	output logic [NCH:0] drv_en_o,
	output logic [NCH:0] cdr_run_o,
	output logic active_o,
	output logic link_clk_seen_o,
	// status pins as tri-state pairs
	output logic lock_o,
	output logic lock_oe_o,
	output logic signal_detect_out_o,
	output logic signal_detect_out_oe_o
);
	trc_regs_t q, d;
	// two-flop synchronised straps
	logic [2:0] eq_s1_q, eq_s2_q;
	logic [1:0] de_s1_q, de_s2_q;
	logic [2:0] misc_s1_q, misc_s2_q;
	// two-flop synchronised analog status levels
	logic pll_s1_q, pll_s2_q;
	logic [NCH-1:0] iok_s1_q, iok_s2_q;
	logic [NCH:0] on_s1_q, on_s2_q, off_s1_q, off_s2_q;
	logic lock_raw, sd_lvl, sd_next, lock_sync, sd_sync, en_eff, bus_req, bus_wr;
	logic [31:0] rd;
	logic sd_q;

	// pin synchronisers: first stage read only by second
	always_ff @(posedge clk_i)
	begin
		eq_s1_q <= boost_select_i;
		eq_s2_q <= eq_s1_q;
		de_s1_q <= deemph_select_i;
		de_s2_q <= de_s1_q;
		misc_s1_q <= {enable_i, mode_i, bypass_i};
		misc_s2_q <= misc_s1_q;
		pll_s1_q <= pll_locked_i;
		pll_s2_q <= pll_s1_q;
		iok_s1_q <= cdr_interp_ok_i;
		iok_s2_q <= iok_s1_q;
		on_s1_q <= above_on_i;
		on_s2_q <= on_s1_q;
		off_s1_q <= below_off_i;
		off_s2_q <= off_s1_q;
	end

	assign lock_raw = pll_s2_q & (&iok_s2_q);
	assign lock_sync = q.lock_s[1];
	assign sd_sync = q.sd_s[1];
	// auto standby follows lock when selected, only outside bypass
	assign en_eff = q.ctrl[TRC_CTRL_EN_BIT] & misc_s2_q[2] &
		(~q.ctrl[TRC_CTRL_AUTO_BIT] | misc_s2_q[0] | lock_sync);
	assign bus_req = wb_cyc_i & wb_stb_i & ~q.ack;
	assign bus_wr = bus_req & wb_we_i;

	// hysteresis: set when all above on, clear when any below off
	always_comb
	begin
		sd_lvl = sd_q;
		if (|off_s2_q)
			sd_lvl = 1'b0;
		else if (&on_s2_q)
			sd_lvl = 1'b1;
	end
	assign sd_next = sd_lvl;

	// raw detect level held in clk domain before sync
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sd_q <= 1'b0;
		else
			sd_q <= sd_next;
	end

	// read mux
	always_comb
	begin
		rd = 32'h0000_0000;
		case (wb_adr_i)
			TRC_CTRL_OFS: rd = {30'h0, q.ctrl};
			TRC_STAT_OFS: rd = {25'h0, q.st == TRC_ACTIVE, misc_s2_q, sd_sync, lock_sync, link_clk_seen_o};
			TRC_IRQ_OFS: rd = {28'h0, q.irq};
			TRC_MASK_OFS: rd = {28'h0, q.mask};
			TRC_EQDB_OFS: rd = {27'h0, q.path.eq_db};
			TRC_DEMV_OFS: rd = {18'h0, q.path.de_db, q.path.de_mv};
			default: rd = 32'h0000_0000;
		endcase
	end

	// next-state logic
	always_comb
	begin
		logic [TRC_NIRQ-1:0] ev;
		ev = '0;
		d = q;
		d.lock_s = {q.lock_s[1:0], lock_raw};
		d.sd_s = {q.sd_s[1:0], sd_q};
		d.lclk_s = {q.lclk_s[1:0], link_clk_i};
		// link clock activity: count down after each seen edge
		if (q.lclk_s[2] != q.lclk_s[1])
			d.lclk_cnt = 8'hff;
		else if (q.lclk_cnt != 8'h00)
			d.lclk_cnt = q.lclk_cnt - 8'h01;
		d.path.eq_db = TRC_EQ_DB[eq_s2_q];
		d.path.de_db = TRC_DE_DB[de_s2_q];
		d.path.de_mv = TRC_DE_MV[de_s2_q];
		d.path.retime_on = ~misc_s2_q[0];
		d.path.deemph_on = ~misc_s2_q[0];
		// clock channel regen when mode low
		d.path.clk_regen = ~misc_s2_q[1];
		case (q.st)
			TRC_STANDBY: if (en_eff) d.st = TRC_ACTIVE;
			TRC_ACTIVE: if (!en_eff) d.st = TRC_STANDBY;
			default: d.st = TRC_STANDBY;
		endcase
		// status events
		ev[TRC_IRQ_LOCK_RISE] = q.lock_s[1] & ~q.lock_s[2];
		ev[TRC_IRQ_LOCK_FALL] = ~q.lock_s[1] & q.lock_s[2];
		ev[TRC_IRQ_SD_RISE] = q.sd_s[1] & ~q.sd_s[2];
		ev[TRC_IRQ_SD_FALL] = ~q.sd_s[1] & q.sd_s[2];
		// bus: ack one cycle after request, dropped the cycle after
		d.ack = bus_req;
		d.dat = bus_req ? rd : q.dat;
		if (bus_wr && wb_sel_i[0])
		begin
			case (wb_adr_i)
				TRC_CTRL_OFS: d.ctrl = wb_dat_i[1:0];
				TRC_MASK_OFS: d.mask = wb_dat_i[TRC_NIRQ-1:0];
				TRC_IRQ_OFS: d.irq = q.irq & ~wb_dat_i[TRC_NIRQ-1:0];
				default: d.ctrl = q.ctrl;
			endcase
		end
		// set wins over write-one-to-clear
		d.irq = d.irq | ev;
	end

	// state register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q <= '0;
			q.st <= TRC_STANDBY;
			q.ctrl <= TRC_CTRL_RST[1:0];
		end
		else
			q <= d;
	end

	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.dat;
	assign irq_o = |(q.irq & q.mask);
	assign active_o = q.st == TRC_ACTIVE;
	assign path_o = q.path;
	assign link_clk_seen_o = q.lclk_cnt != 8'h00;

	// one recovery enable per channel, data channels from active and retime, the clock channel from active and clock regen
	genvar g;
	generate
		for (g = 0; g <= NCH; g++)
		begin : g_ch
			assign drv_en_o[g] = active_o;
			if (g < NCH)
			begin : g_cdr
				// recovery runs at any rate while retiming
				assign cdr_run_o[g] = active_o & q.path.retime_on;
			end
			else
			begin : g_clk
				assign cdr_run_o[g] = active_o & q.path.clk_regen;
			end
		end
	endgenerate

	// lock pin level; auto standby uses the internal copy, so the pin may float
	assign lock_o = lock_sync;
	assign lock_oe_o = active_o;
	// detect pin, high impedance in standby
	assign signal_detect_out_o = sd_sync;
	assign signal_detect_out_oe_o = active_o;

	// assertions
	// standby drivers off
	a_standby_drv_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!active_o |-> (drv_en_o == '0 && !signal_detect_out_oe_o && !lock_oe_o)) else $error("drivers on in standby");

	a_bypass_no_retime: assert property (@(posedge clk_i) disable iff (rst_i)
		misc_s2_q[0] |=> !path_o.retime_on && !path_o.deemph_on) else $error("retiming on in bypass");

	a_mode_clk_pass: assert property (@(posedge clk_i) disable iff (rst_i)
		misc_s2_q[1] |=> !path_o.clk_regen) else $error("clock regen in pass mode");

	a_eq_decode_max: assert property (@(posedge clk_i) disable iff (rst_i)
		eq_s2_q == 3'h7 |=> path_o.eq_db == 5'h1b) else $error("boost decode wrong");

	a_de_decode_mv: assert property (@(posedge clk_i) disable iff (rst_i)
		de_s2_q == 2'h1 |=> path_o.de_mv == 10'h2c6 && path_o.de_db == 4'h3) else $error("de-emphasis decode wrong");

	// lock needs pll, four stages of sync behind
	a_lock_needs_pll: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(lock_o) |-> $past(pll_locked_i, 4)) else $error("lock without pll");

	// off threshold wins after the sync stages
	a_detect_off_threshold_wins: assert property (@(posedge clk_i) disable iff (rst_i)
		(|below_off_i) |-> ##5 !signal_detect_out_o) else $error("detect high below off");

	a_auto_standby: assert property (@(posedge clk_i) disable iff (rst_i)
		(q.ctrl[TRC_CTRL_AUTO_BIT] && !misc_s2_q[0] && !lock_sync) |=> !active_o) else $error("no auto standby");

	a_enable_active: assert property (@(posedge clk_i) disable iff (rst_i)
		en_eff |=> active_o && cdr_run_o[0] == path_o.retime_on) else $error("not active when enabled");

	a_eq_decode_min: assert property (@(posedge clk_i) disable iff (rst_i)
		eq_s2_q == 3'h0 |=> path_o.eq_db == 5'h00) else $error("boost decode low wrong");

	a_eq_decode_one: assert property (@(posedge clk_i) disable iff (rst_i)
		eq_s2_q == 3'h1 |=> path_o.eq_db == 5'h0a) else $error("boost decode one wrong");

	a_eq_decode_mid: assert property (@(posedge clk_i) disable iff (rst_i)
		eq_s2_q == 3'h4 |=> path_o.eq_db == 5'h17) else $error("boost decode mid wrong");

	a_de_decode_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		de_s2_q == 2'h0 |=> path_o.de_db == 4'h0 && path_o.de_mv == 10'h3e8) else $error("de-emphasis zero wrong");

	a_de_decode_max: assert property (@(posedge clk_i) disable iff (rst_i)
		de_s2_q == 2'h3 |=> path_o.de_db == 4'h9 && path_o.de_mv == 10'h163) else $error("de-emphasis max wrong");

	a_normal_retime: assert property (@(posedge clk_i) disable iff (rst_i)
		!misc_s2_q[0] |=> path_o.retime_on && path_o.deemph_on) else $error("retiming off in normal mode");

	a_mode_clk_regen: assert property (@(posedge clk_i) disable iff (rst_i)
		!misc_s2_q[1] |=> path_o.clk_regen) else $error("clock not regenerated");

	a_retime_off_cdr: assert property (@(posedge clk_i) disable iff (rst_i)
		!path_o.retime_on |-> cdr_run_o[NCH-1:0] == '0) else $error("recovery running in bypass");

	a_pin_enable_active: assert property (@(posedge clk_i) disable iff (rst_i)
		misc_s2_q[2] && q.ctrl[TRC_CTRL_EN_BIT] && !q.ctrl[TRC_CTRL_AUTO_BIT] |=> active_o) else $error("enable ignored");

	a_standby_when_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!misc_s2_q[2] |=> !active_o) else $error("active with enable low");

	a_lock_drops: assert property (@(posedge clk_i) disable iff (rst_i)
		!pll_locked_i |-> ##4 !lock_o) else $error("lock high without pll");

	a_lock_needs_cdr: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(lock_o) |-> $past(cdr_interp_ok_i, 4) == '1) else $error("lock without recovery");

	// detect rises only with all channels on
	a_sd_needs_on: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(signal_detect_out_o) |-> $past(above_on_i, 5) == '1) else $error("detect without all channels");

	a_auto_bypass_stays: assert property (@(posedge clk_i) disable iff (rst_i)
		q.ctrl == 2'b11 && misc_s2_q[2] && misc_s2_q[0] |=> active_o) else $error("standby in bypass");

	a_auto_lock_wakes: assert property (@(posedge clk_i) disable iff (rst_i)
		q.ctrl == 2'b11 && misc_s2_q[2] && lock_sync |=> active_o) else $error("no wake on lock");

	// lock rise sets its sticky bit
	a_irq_lock_rise: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(lock_sync) |=> q.irq[TRC_IRQ_LOCK_RISE]) else $error("lock rise not flagged");

	// detect rise sets its sticky bit
	a_irq_sd_rise: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(sd_sync) |=> q.irq[TRC_IRQ_SD_RISE]) else $error("detect rise not flagged");

	// link clock edge marks activity
	a_lclk_seen: assert property (@(posedge clk_i) disable iff (rst_i) // link
		q.lclk_s[2] != q.lclk_s[1] |=> link_clk_seen_o) else $error("link clock edge missed");

	// ack is a one-cycle pulse
	a_bus_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // bus
		wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");

	// every request answered next cycle
	a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i) // bus
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acknowledged");

	// cover points for the main scenarios
	c_auto_cycle: cover property (@(posedge clk_i) disable iff (rst_i)
		!active_o ##1 active_o ##[1:50] !active_o);
	c_irq_fire: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
	c_bypass: cover property (@(posedge clk_i) disable iff (rst_i) active_o && misc_s2_q[0]);
	c_lock_rise: cover property (@(posedge clk_i) disable iff (rst_i) $rose(lock_o));
	c_standby_entry: cover property (@(posedge clk_i) disable iff (rst_i) $fell(active_o));
endmodule : trc_ctrl

// ===== core/trc_pkg.sv
// package for the retimer control block: register map, field values, state codes
// assumes a 125 MHz system clock and a classic wishbone slave with 32-bit data
package trc_pkg;
	// register byte offsets
	localparam logic [7:0] TRC_CTRL_OFS = 8'h00;
	localparam logic [7:0] TRC_STAT_OFS = 8'h04;
	localparam logic [7:0] TRC_IRQ_OFS = 8'h08;
	localparam logic [7:0] TRC_MASK_OFS = 8'h0c;
	localparam logic [7:0] TRC_EQDB_OFS = 8'h10;
	localparam logic [7:0] TRC_DEMV_OFS = 8'h14;
	// ctrl field positions
	localparam int TRC_CTRL_EN_BIT = 0;
	localparam int TRC_CTRL_AUTO_BIT = 1;
	localparam logic [31:0] TRC_CTRL_RST = 32'h0000_0001;
	// irq bits
	localparam int TRC_IRQ_LOCK_RISE = 0;
	localparam int TRC_IRQ_LOCK_FALL = 1;
	localparam int TRC_IRQ_SD_RISE = 2;
	localparam int TRC_IRQ_SD_FALL = 3;
	localparam int TRC_NIRQ = 4;
	// boost select to gain in dB
	localparam logic [4:0] TRC_EQ_DB [8] = '{5'h00, 5'h0a, 5'h10, 5'h13, 5'h17, 5'h19, 5'h1a, 5'h1b};
	// de-emphasis select to attenuation in dB (magnitude) and level in mVp-p
	localparam logic [3:0] TRC_DE_DB [4] = '{4'h0, 4'h3, 4'h6, 4'h9};
	localparam logic [9:0] TRC_DE_MV [4] = '{10'h3e8, 10'h2c6, 10'h1f4, 10'h163};
	// device power state
	typedef enum logic [1:0] {
		TRC_STANDBY = 2'b01,
		TRC_ACTIVE = 2'b10
	} trc_state_t;
	// decoded path settings
	typedef struct packed {
		logic [4:0] eq_db;
		logic [3:0] de_db;
		logic [9:0] de_mv;
		logic retime_on;
		logic deemph_on;
		logic clk_regen;
	} trc_path_t;
	// registered state apart from the pin synchronisers and sd_q; the lock, detect and link clock sync stages are in here
	typedef struct packed {
		trc_state_t st;
		logic [1:0] ctrl;
		logic [TRC_NIRQ-1:0] irq;
		logic [TRC_NIRQ-1:0] mask;
		logic [2:0] lock_s;
		logic [2:0] sd_s;
		logic [2:0] lclk_s;
		logic ack;
		logic [31:0] dat;
		trc_path_t path;
		logic [7:0] lclk_cnt;
	} trc_regs_t;
endpackage : trc_pkg

// ===== dv/tb.sv
// self-checking bench of the retimer control block
// assumes trc_far on the analog side, wishbone reads checked from a queue
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import trc_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rs = 32'hef8e0ac6, rdat;
	logic [2:0] boost = 3'h0, bad = 3'h0, iok;
	logic [1:0] de = 2'h0;
	logic byp = 1'b0, mode = 1'b0, en = 1'b1, lreq = 1'b0, sreq = 1'b0, run = 1'b0;
	logic pl, lclk, ack, irq, act, seen, lk, lk_oe, sd, sd_oe;
	logic [3:0] aon, boff, drv, cdr;
	trc_path_t path;
	logic [31:0] exp_q [$];
	int miscompares = 0, checked = 0;
	// expected gains and {dB, mVp-p} pairs
	logic [4:0] eqt [8] = '{5'h00, 5'h0a, 5'h10, 5'h13, 5'h17, 5'h19, 5'h1a, 5'h1b};
	logic [13:0] det [4] = '{14'h03e8, 14'h0ec6, 14'h19f4, 14'h2563};
	initial forever #4 clk_i = ~clk_i;
	trc_ctrl i_trc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .boost_select_i(boost),
		.deemph_select_i(de), .bypass_i(byp), .mode_i(mode), .enable_i(en), .pll_locked_i(pl), .cdr_interp_ok_i(iok),
		.above_on_i(aon), .below_off_i(boff), .link_clk_i(lclk), .path_o(path), .drv_en_o(drv), .cdr_run_o(cdr),
		.active_o(act), .link_clk_seen_o(seen), .lock_o(lk), .lock_oe_o(lk_oe), .signal_detect_out_o(sd),
		.signal_detect_out_oe_o(sd_oe));
	trc_far i_trc_far (.clk_i(clk_i), .lock_req_i(lreq), .sd_req_i(sreq), .run_i(run), .bad_i(bad),
		.pll_locked_o(pl), .interp_ok_o(iok), .above_on_o(aon), .below_off_o(boff), .link_clk_o(lclk));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic close_out();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e)
		begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// one classic cycle, held until ack is sampled; bounded wait
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50)
		begin
			miscompares++;
			close_out();
		end
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	// let straps cross the synchronisers, then settle
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : wt
	// read answers against the oldest note
	always @(posedge clk_i)
		if (ack === 1'b1 && we === 1'b0)
			chk("read data", (exp_q.size() > 0) ? exp_q.pop_front() : ~rdat, rdat);
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(TRC_CTRL_OFS, 32'h1);
		rd(TRC_IRQ_OFS, 32'h0);
		rd(8'h40, 32'h0);
		rs = xs(rs);
		bus(1'b1, TRC_MASK_OFS, rs);
		rd(TRC_MASK_OFS, 32'(rs[3:0]));
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk_i);
			boost <= 3'(i);
			de <= 2'(i);
			wt(6);
			chk("eq", 32'(eqt[i]), 32'(path.eq_db));
			chk("deemph", 32'(det[i % 4]), {18'h0, path.de_db, path.de_mv});
			rd(TRC_EQDB_OFS, 32'(eqt[i]));
		end
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_i);
			byp <= i[0];
			// mode high as on a middle hop
			mode <= i[1];
			wt(6);
			chk("modes", {29'h0, !i[0], !i[0], !i[1]}, {29'h0, path.retime_on, path.deemph_on, path.clk_regen});
		end
		@(posedge clk_i);
		byp <= 1'b0;
		mode <= 1'b0;
		en <= 1'b0;
		wt(8);
		chk("standby", 32'h0, {25'h0, act, drv, lk_oe, sd_oe});
		@(posedge clk_i);
		en <= 1'b1;
		lreq <= 1'b1;
		sreq <= 1'b1;
		bad <= 3'b010;
		bus(1'b1, TRC_MASK_OFS, 32'h2);
		wt(12);
		chk("active", 32'h1ff, {23'h0, act, drv, cdr});
		chk("lock one unit bad", 32'h0, {30'h0, lk, sd});
		@(posedge clk_i);
		bad <= 3'h0;
		run <= 1'b1;
		wt(40);
		chk("lock detect", 32'h3, {30'h0, lk, sd});
		rd(TRC_STAT_OFS, 32'h67);
		rd(TRC_IRQ_OFS, 32'h5);
		chk("irq masked", 32'h0, 32'(irq));
		@(posedge clk_i);
		lreq <= 1'b0;
		wt(12);
		chk("irq", 32'h1, 32'(irq));
		rd(TRC_IRQ_OFS, 32'h7);
		bus(1'b1, TRC_IRQ_OFS, 32'h7);
		wt(2);
		chk("irq cleared", 32'h0, 32'(irq));
		bus(1'b1, TRC_CTRL_OFS, 32'h3);
		wt(4);
		chk("auto standby", 32'h0, 32'(act));
		@(posedge clk_i);
		lreq <= 1'b1;
		wt(12);
		chk("auto active", 32'h1, 32'(act));
		@(posedge clk_i);
		byp <= 1'b1;
		lreq <= 1'b0;
		wt(12);
		chk("bypass keeps active", 32'h1, 32'(act));
		close_out();
	end
endmodule : tb

// ===== dv/trc_far.sv
// far-side model: pll, recovery units, detect comparators, link clock
// assumes the bench commands lock, detect, clock running and faulty channels
module trc_far (
	input wire logic clk_i,
	input wire logic lock_req_i,
	input wire logic sd_req_i,
	input wire logic run_i,
	input wire logic [2:0] bad_i,
	output logic pll_locked_o,
	output logic [2:0] interp_ok_o,
	output logic [3:0] above_on_o,
	output logic [3:0] below_off_o,
	output logic link_clk_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] lk_q = 4'h0;
	// units interpolate together, four cycles after lock unless faulty
	always @(posedge clk_i)
		lk_q <= {lk_q[2:0], lock_req_i};
	assign pll_locked_o = lock_req_i;
	assign interp_ok_o = {3{lk_q[3]}} & ~bad_i;
	// faulty channel drops under the off level
	assign above_on_o = {4{sd_req_i}} & ~{1'b0, bad_i};
	assign below_off_o = ~above_on_o;
	// clock stands still outside frames
	initial link_clk_o = 1'b0;
	always #62.5 if (run_i) link_clk_o = ~link_clk_o;
endmodule : trc_far
